//--- rtl/cim_pkg.sv
// constants, register map and carrier types of the counter input measurement block
// assumes a 32-bit apb slave and a single 20 mhz clock
package cim_pkg;
	localparam int unsigned CNT_W = 32;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_COUNT = 12'h004;
	localparam logic [11:0] OFF_SAVE = 12'h008;
	localparam logic [11:0] OFF_STAT = 12'h00C;
	localparam logic [11:0] OFF_INIT = 12'h010;
	// control register fields
	localparam int unsigned CTRL_ARM = 0;
	localparam int unsigned CTRL_SRC_FALL = 1;
	localparam int unsigned CTRL_GATE_POL = 2;
	localparam int unsigned CTRL_DIR_LSB = 3;
	localparam int unsigned CTRL_MODE_LSB = 5;
	localparam int unsigned CTRL_BUF = 8;
	localparam int unsigned CTRL_PAUSE_EN = 9;
	localparam int unsigned CTRL_NONCUM = 10;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] INIT_RST = 32'h0000_0000;
	// status register fields
	localparam int unsigned STAT_DONE = 0;
	localparam int unsigned STAT_ACTIVE = 1;
	localparam int unsigned STAT_OVR = 2;

	typedef enum logic [2:0] {
		CIM_EDGE = 3'b000,
		CIM_PWIDTH = 3'b001,
		CIM_PERIOD = 3'b010,
		CIM_SEMI = 3'b011
	} cim_mode_e;

	typedef enum logic [1:0] {
		CIM_UP = 2'b00,
		CIM_DOWN = 2'b01,
		CIM_EXT = 2'b10
	} cim_dir_e;

	typedef enum logic [1:0] {
		CIM_IDLE = 2'b00,
		CIM_WAIT = 2'b01,
		CIM_RUN = 2'b10,
		CIM_DONE = 2'b11
	} cim_state_e;

	typedef struct packed {
		logic [31:0] data;
		logic valid;
	} cim_stream_s;
endpackage

//--- rtl/cim_counter.sv
// counter input measurement: edge count, pulse width, period, semi-period
// assumes inputs synchronous-ish to i_mclk; stream sink gives ready
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - armed counter counts counted-input edges, rising or falling selectable
// - edge counting direction: up, down, or follows direction input
// - software reads count anytime without disturbing counting
// - active pause trigger makes counter ignore counted-input edges
// - pause polarity selectable, high or low
// - buffered edge count captures on selected sample clock edge, streams out
// - cumulative buffered: sample edge never clears counter
// - buffered edge accumulation starts at arming
// - non-cumulative buffered: capture then restart from initial count
// - pulse width counts edges only while control is at selected level
// - armed while control active: wait for next entry into active
// - single pulse width latches at trailing edge then ignores everything
// - buffered pulse width latches and streams every trailing edge
// - period counts edges between consecutive selected control edges
// - single period latches at second active edge then stops
// - buffered period starts at first active edge, no partial value
// - interval with no counted edges stores the initial count
// - semi-period counts between any two consecutive control edges
// - buffered semi-period latches and streams on every control edge
// - buffered semi-period starts at first active edge, no partial value
// - single semi-period behaves as single pulse width
// - counter is 32 bits wide
module cim_counter #(
	parameter int unsigned SYNC_STAGES = 2
) (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_SRC,
	input wire logic I_GATE,
	input wire logic I_DIR,
	output logic [31:0] O_STREAM_DATA,
	output logic O_STREAM_VALID,
	input wire logic I_STREAM_READY
);
	typedef struct packed {
		logic [SYNC_STAGES-1:0] src_sy;
		logic [SYNC_STAGES-1:0] gate_sy;
		logic [SYNC_STAGES-1:0] dir_sy;
		logic src_d;
		logic gate_d;
		logic [31:0] ctrl;
		logic [31:0] init;
		logic [cim_pkg::CNT_W-1:0] count;
		logic [cim_pkg::CNT_W-1:0] save;
		cim_pkg::cim_state_e state;
		logic done;
		logic ovr;
		cim_pkg::cim_stream_s strm;
		logic [31:0] prdata;
	} cim_state_s;

	cim_state_s s_r;
	cim_state_s s_nxt;

	function automatic logic [31:0] cim_step(input logic [31:0] v, input logic up);
		cim_step = up ? v + 32'h0000_0001 : v - 32'h0000_0001;
	endfunction

	// one decode serves the error flag; keeps the map in one place
	function automatic logic cim_mapped(input logic [11:0] a);
		cim_mapped = (a == cim_pkg::OFF_CTRL) || (a == cim_pkg::OFF_COUNT)
			|| (a == cim_pkg::OFF_SAVE) || (a == cim_pkg::OFF_STAT)
			|| (a == cim_pkg::OFF_INIT);
	endfunction

	// every capture path loads the stream word the same way
	function automatic cim_pkg::cim_stream_s cim_push(input logic [31:0] v);
		cim_pkg::cim_stream_s w;
		w.data = v;
		w.valid = 1'b1;
		return w;
	endfunction

	logic src_now, gate_now, dir_now, src_edge, gate_rise, gate_fall, gate_any;
	logic gate_act_lvl, gate_act_edge, gate_trail, src_hit, up, buffered, armed;
	logic wr, rd, ovr_set, ovr_clr;
	cim_pkg::cim_mode_e mode;
	cim_pkg::cim_dir_e dirsel;

	always_comb begin
		s_nxt = s_r;
		ovr_set = 1'b0;
		ovr_clr = 1'b0;
		// last stage only; first stage feeds the second and nothing else
		src_now = s_r.src_sy[SYNC_STAGES-1];
		gate_now = s_r.gate_sy[SYNC_STAGES-1];
		dir_now = s_r.dir_sy[SYNC_STAGES-1];
		s_nxt.src_sy = {s_r.src_sy[SYNC_STAGES-2:0], I_SRC};
		s_nxt.gate_sy = {s_r.gate_sy[SYNC_STAGES-2:0], I_GATE};
		s_nxt.dir_sy = {s_r.dir_sy[SYNC_STAGES-2:0], I_DIR};
		s_nxt.src_d = src_now;
		s_nxt.gate_d = gate_now;
		src_edge = s_r.ctrl[cim_pkg::CTRL_SRC_FALL] ? (s_r.src_d & ~src_now)
			: (~s_r.src_d & src_now);
		gate_rise = ~s_r.gate_d & gate_now;
		gate_fall = s_r.gate_d & ~gate_now;
		gate_any = gate_rise | gate_fall;
		// gate polarity bit: 0 selects high level / rising edge
		gate_act_lvl = gate_now ^ s_r.ctrl[cim_pkg::CTRL_GATE_POL];
		gate_act_edge = s_r.ctrl[cim_pkg::CTRL_GATE_POL] ? gate_fall : gate_rise;
		gate_trail = s_r.ctrl[cim_pkg::CTRL_GATE_POL] ? gate_rise : gate_fall;
		mode = cim_pkg::cim_mode_e'(s_r.ctrl[cim_pkg::CTRL_MODE_LSB +: 3]);
		dirsel = cim_pkg::cim_dir_e'(s_r.ctrl[cim_pkg::CTRL_DIR_LSB +: 2]);
		buffered = s_r.ctrl[cim_pkg::CTRL_BUF];
		armed = s_r.ctrl[cim_pkg::CTRL_ARM];
		up = 1'b1;
		if (mode == cim_pkg::CIM_EDGE) begin
			unique case (dirsel)
				cim_pkg::CIM_UP: up = 1'b1;
				cim_pkg::CIM_DOWN: up = 1'b0;
				cim_pkg::CIM_EXT: up = dir_now;
				default: up = 1'b1;
			endcase
		end
		src_hit = src_edge;
		// stream handshake completes independently of counting
		if (s_r.strm.valid && I_STREAM_READY) begin
			s_nxt.strm.valid = 1'b0;
		end
		if (!armed) begin
			s_nxt.state = cim_pkg::CIM_IDLE;
		end else begin
			unique case (s_r.state)
				cim_pkg::CIM_IDLE: begin
					s_nxt.count = s_r.init;
					s_nxt.done = 1'b0;
					if (mode == cim_pkg::CIM_EDGE) begin
						s_nxt.state = cim_pkg::CIM_RUN;
					end else if (mode == cim_pkg::CIM_PWIDTH
						|| (mode == cim_pkg::CIM_SEMI && !buffered)) begin
						// armed mid-pulse: wait for a fresh entry into active
						s_nxt.state = cim_pkg::CIM_WAIT;
					end else begin
						s_nxt.state = cim_pkg::CIM_WAIT;
					end
				end
				cim_pkg::CIM_WAIT: begin
					s_nxt.count = s_r.init;
					if ((mode == cim_pkg::CIM_PWIDTH || mode == cim_pkg::CIM_SEMI) && !buffered) begin
						if (gate_act_lvl && (gate_rise | gate_fall)) begin
							s_nxt.state = cim_pkg::CIM_RUN;
						end
					end else if (mode == cim_pkg::CIM_PWIDTH) begin
						if (gate_act_lvl && gate_any) begin
							s_nxt.state = cim_pkg::CIM_RUN;
						end
					end else if (gate_act_edge) begin
						s_nxt.state = cim_pkg::CIM_RUN;
					end
				end
				cim_pkg::CIM_RUN: begin
					unique case (mode)
						cim_pkg::CIM_EDGE: begin
							if (src_hit && !(s_r.ctrl[cim_pkg::CTRL_PAUSE_EN] && !gate_act_lvl)) begin
								// pause when gate sits at the inactive level
								s_nxt.count = cim_step(s_r.count, up);
							end
							if (buffered && gate_act_edge) begin
								s_nxt.strm = cim_push(s_r.count);
								ovr_set = s_r.strm.valid & ~I_STREAM_READY;
								if (s_r.ctrl[cim_pkg::CTRL_NONCUM]) begin
									s_nxt.count = s_r.init;
								end // otherwise keep accumulating
							end
						end
						cim_pkg::CIM_PWIDTH: begin
							if (src_hit && gate_act_lvl) begin
								s_nxt.count = cim_step(s_r.count, 1'b1);
							end
							if (gate_trail) begin
								s_nxt.save = s_r.count;
								s_nxt.count = s_r.init;
								if (buffered) begin
									s_nxt.strm = cim_push(s_r.count);
									ovr_set = s_r.strm.valid & ~I_STREAM_READY;
								end else begin
									s_nxt.state = cim_pkg::CIM_DONE;
									s_nxt.done = 1'b1;
								end
							end
						end
						cim_pkg::CIM_PERIOD, cim_pkg::CIM_SEMI: begin
							if (mode == cim_pkg::CIM_SEMI && !buffered) begin
								if (src_hit && gate_act_lvl) begin
									s_nxt.count = cim_step(s_r.count, 1'b1);
								end
								if (gate_trail) begin
									s_nxt.save = s_r.count;
									s_nxt.state = cim_pkg::CIM_DONE;
									s_nxt.done = 1'b1;
								end
							end else begin
								if (src_hit) begin
									s_nxt.count = cim_step(s_r.count, 1'b1);
								end
								if ((mode == cim_pkg::CIM_PERIOD) ? gate_act_edge : gate_any) begin
									// initial count when no counted edge in the interval
									s_nxt.save = s_r.count;
									s_nxt.count = s_r.init;
									if (buffered) begin
										s_nxt.strm = cim_push(s_r.count);
										ovr_set = s_r.strm.valid & ~I_STREAM_READY;
									end else begin
										s_nxt.state = cim_pkg::CIM_DONE;
										s_nxt.done = 1'b1;
									end
								end
							end
						end
						default: s_nxt.state = cim_pkg::CIM_DONE;
					endcase
				end
				cim_pkg::CIM_DONE: begin
					s_nxt.state = cim_pkg::CIM_DONE;
				end
			endcase
		end
		// apb slave: zero wait state, unmapped reads zero with pslverr
		wr = I_PSEL && I_PENABLE && I_PWRITE;
		rd = I_PSEL && !I_PENABLE && !I_PWRITE;
		if (wr) begin
			unique case (I_PADDR)
				cim_pkg::OFF_CTRL: s_nxt.ctrl = I_PWDATA;
				cim_pkg::OFF_INIT: s_nxt.init = I_PWDATA;
				cim_pkg::OFF_STAT: begin
					ovr_clr = I_PWDATA[cim_pkg::STAT_OVR];
				end
				default: ;
			endcase
		end
		// write one to clear; a word lost in the clearing cycle still reports
		s_nxt.ovr = ovr_set | (s_r.ovr & ~ovr_clr);
		if (rd) begin
			unique case (I_PADDR)
				cim_pkg::OFF_CTRL: s_nxt.prdata = s_r.ctrl;
				cim_pkg::OFF_COUNT: s_nxt.prdata = s_r.count;
				cim_pkg::OFF_SAVE: s_nxt.prdata = s_r.save;
				cim_pkg::OFF_INIT: s_nxt.prdata = s_r.init;
				cim_pkg::OFF_STAT: s_nxt.prdata = {29'h0000_0000, s_r.ovr,
					(s_r.state == cim_pkg::CIM_RUN), s_r.done};
				default: s_nxt.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			s_r <= '0;
			s_r.ctrl <= cim_pkg::CTRL_RST;
			s_r.init <= cim_pkg::INIT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign O_PRDATA = s_r.prdata;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !cim_mapped(I_PADDR);
	assign O_STREAM_DATA = s_r.strm.data;
	assign O_STREAM_VALID = s_r.strm.valid;
endmodule

`default_nettype wire

//--- verification/cim_counter_assertions.sv
// checker for the counter block: apb answers and stream capture relations
// assumes it is bound onto cim_counter and that one clock domain covers all
`timescale 1ns/1ns
`default_nettype none
module cim_counter_assertions #(
	parameter int unsigned SYNC_STAGES = 2
) (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic I_GATE,
	input wire logic [31:0] O_STREAM_DATA,
	input wire logic O_STREAM_VALID,
	input wire logic I_STREAM_READY
);
	logic [31:0] ctrl_r;
	logic gate_q;
	logic [7:0] gap_r;
	logic acc;
	logic unm;
	assign acc = I_PSEL && I_PENABLE;
	assign unm = !(I_PADDR == cim_pkg::OFF_CTRL || I_PADDR == cim_pkg::OFF_COUNT
		|| I_PADDR == cim_pkg::OFF_SAVE || I_PADDR == cim_pkg::OFF_STAT
		|| I_PADDR == cim_pkg::OFF_INIT);
	// age of the last gate change; captures must follow one closely
	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			ctrl_r <= cim_pkg::CTRL_RST;
			gate_q <= 1'b0;
			gap_r <= 8'hFF;
		end else begin
			if (acc && I_PWRITE && I_PADDR == cim_pkg::OFF_CTRL) ctrl_r <= I_PWDATA;
			gate_q <= I_GATE;
			gap_r <= (I_GATE != gate_q) ? 8'h00 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
		end
	end
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RESET);
	property p_rdy; acc |-> O_PREADY; endproperty
	a_rdy: assert property (p_rdy) else $error("access without ready");
	property p_err; acc && unm |-> O_PSLVERR; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_noerr; acc && !unm |-> !O_PSLVERR; endproperty
	a_noerr: assert property (p_noerr) else $error("mapped access refused");
	property p_rdz; acc && !I_PWRITE && unm |-> O_PRDATA == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
	property p_rdctl;
		acc && !I_PWRITE && I_PADDR == cim_pkg::OFF_CTRL |-> O_PRDATA == ctrl_r;
	endproperty
	a_rdctl: assert property (p_rdctl) else $error("control readback wrong");
	property p_hold;
		O_STREAM_VALID && !I_STREAM_READY |=> O_STREAM_VALID && $stable(O_STREAM_DATA);
	endproperty
	a_hold: assert property (p_hold) else $error("stream word dropped");
	property p_buf;
		$rose(O_STREAM_VALID) |-> ctrl_r[cim_pkg::CTRL_ARM] && ctrl_r[cim_pkg::CTRL_BUF];
	endproperty
	a_buf: assert property (p_buf) else $error("stream word outside buffered run");
	property p_gap;
		$rose(O_STREAM_VALID) |-> gap_r >= 8'h01 && gap_r <= SYNC_STAGES + 6;
	endproperty
	a_gap: assert property (p_gap) else $error("capture not tied to gate edge");
endmodule
bind cim_counter cim_counter_assertions #(.SYNC_STAGES(SYNC_STAGES)) i_chk (.I_MCLK(I_MCLK),
	.I_RESET(I_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .I_GATE(I_GATE), .O_STREAM_DATA(O_STREAM_DATA),
	.O_STREAM_VALID(O_STREAM_VALID), .I_STREAM_READY(I_STREAM_READY));
`default_nettype wire

//--- verification/cim_sig_src.sv
// model of the external counted and control signals
// assumes the bench stops it around every reconfiguration
`timescale 1ns/1ns
`default_nettype none
module cim_sig_src (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic i_src_en,
	input wire logic [3:0] i_gate_half,
	output logic o_src,
	output logic o_gate
);
	logic [7:0] c_r;
	// src and gate move on different phases so their order is never ambiguous
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			c_r <= 8'h00;
			o_src <= 1'b0;
			o_gate <= 1'b0;
		end else if (i_run) begin
			c_r <= (c_r == {2'b00, i_gate_half, 2'b11}) ? 8'h00 : c_r + 8'h01;
			if (c_r[1:0] == 2'b01 && i_src_en) o_src <= !o_src;
			if (c_r == 8'h00) o_gate <= !o_gate;
		end
	end
endmodule
`default_nettype wire

//--- verification/cim_counter_tb.sv
// self-checking bench for the counter block with a reference model
// assumes cim_sig_src drives the counted and control inputs
`timescale 1ns/1ns
`default_nettype none
module cim_counter_tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, dir = 1'b0;
	logic srdy = 1'b0, run = 1'b0, sen = 1'b1, prdy, perr, svld, src, gate;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, sdat, cnt, sav, ini;
	logic [3:0] gh = 4'h3;
	logic [2:0] m;
	logic [1:0] dr, st;
	logic act = 1'b0, b, nc, pe, pol, fl, ps, pg, se, ge, ga, en;
	logic [31:0] q[$];
	logic [31:0] exp_w;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	cim_counter i_cim_counter (.I_MCLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
		.O_PSLVERR(perr), .I_SRC(src), .I_GATE(gate), .I_DIR(dir), .O_STREAM_DATA(sdat),
		.O_STREAM_VALID(svld), .I_STREAM_READY(srdy));
	cim_sig_src i_cim_sig_src (.i_clk(clk), .i_rst(rst), .i_run(run), .i_src_en(sen),
		.i_gate_half(gh), .o_src(src), .o_gate(gate));
	always #25 clk = !clk;
	task automatic complete_run;
		if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		r = prd;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	// pin-level model; the design's fixed input latency delays all edges alike
	always @(posedge clk) begin
		se = src !== ps && src !== fl;
		ge = gate !== pg;
		ga = ge && gate !== pol;
		ps = src;
		pg = gate;
		if (act && m == 3'd0) begin
			if (se && !(pe && gate == pol)) begin
				cnt = (dr == 2'd1 || (dr == 2'd2 && !dir)) ? cnt - 1 : cnt + 1;
			end
			if (ga && b) begin
				q.push_back(cnt);
				if (nc) cnt = ini;
			end
		end else if (act) begin
			en = m == 3'd2 ? ga : (m == 3'd3 && b ? ge : ge && !ga);
			if (se && st == 2'd1) cnt = cnt + 1;
			if (st == 2'd1 && en) begin
				if (b) q.push_back(cnt);
				else sav = cnt;
				cnt = 32'h0;
				st = !b ? 2'd2 : (m == 3'd1 ? 2'd0 : 2'd1);
			end else if (st == 2'd0 && ga) begin
				st = 2'd1;
				cnt = 32'h0;
			end
		end
	end
	// host sink stalls now and then
	always @(posedge clk) begin
		srdy <= ($urandom % 4) != 0;
		if (svld === 1'b1 && srdy === 1'b1) begin
			exp_w = q.size() ? q.pop_front() : 32'hFFFF_FFFF;
			chk("stream", sdat, exp_w);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			complete_run;
		end
	end
	initial begin
		logic [31:0] r;
		void'($urandom(14));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, cim_pkg::OFF_CTRL, 32'h0, r);
		chk("ctrl", r, cim_pkg::CTRL_RST);
		apb(1'b0, 12'h020, 32'h0, r);
		chk("unmapped", r, 32'h0);
		for (int i = 0; i < 16; i++) begin
			m = 3'(i % 4);
			b = i[2];
			nc = i[3];
			fl = 1'($urandom % 2);
			pol = 1'($urandom % 2);
			pe = m == 3'd0 && ($urandom % 2);
			dr = m == 3'd0 ? 2'((i / 4) % 3) : 2'd0;
			ini = m == 3'd0 ? $urandom : 32'h0;
			dir <= 1'($urandom % 2);
			gh <= 4'(3 + $urandom % 8);
			sen <= i != 6;
			apb(1'b1, cim_pkg::OFF_INIT, ini, r);
			q.delete();
			cnt = ini;
			sav = 32'h0;
			st = m == 3'd0 ? 2'd1 : 2'd0;
			act = 1'b1;
			apb(1'b1, cim_pkg::OFF_CTRL, {21'h0, nc, pe, b, m, dr, pol, fl, 1'b1}, r);
			run <= 1'b1;
			repeat (20) begin
				repeat (20) @(posedge clk);
				apb(1'b0, cim_pkg::OFF_COUNT, 32'h0, r);
			end
			run <= 1'b0;
			repeat (12) @(posedge clk);
			act = 1'b0;
			chk("left", q.size(), 32'h0);
			apb(1'b0, m == 3'd0 ? cim_pkg::OFF_COUNT : cim_pkg::OFF_SAVE, 32'h0, r);
			if (m == 3'd0) chk("count", r, cnt);
			else if (!b) chk("save", r, sav);
			apb(1'b0, cim_pkg::OFF_STAT, 32'h0, r);
			chk("status", r, {29'h0, 1'b0, st != 2'd2, st == 2'd2});
			apb(1'b1, cim_pkg::OFF_CTRL, 32'h0, r);
		end
		complete_run;
	end
endmodule
`default_nettype wire
